// [bcce_pkg.sv]
// constants and types for the branch/call/clear execution unit
package bcce_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_INSTR   = 8'h00;
    localparam logic [7:0] OFS_PC      = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_WREG    = 8'h0c;
    localparam logic [7:0] OFS_BANK    = 8'h10;
    localparam logic [7:0] OFS_SHADOW  = 8'h14;
    localparam logic [7:0] OFS_RET_TOP = 8'h18;
    localparam logic [7:0] OFS_FLAGS   = 8'h1c;

    // status register fields
    localparam int ST_Z_BIT  = 2;
    localparam int ST_OV_BIT = 3;
    // flags register fields
    localparam int FL_BUSY_BIT  = 0;
    localparam int FL_TMO_BIT   = 1;
    localparam int FL_PWRDN_BIT = 2;
    localparam int FL_WAIT2_BIT = 3;
    localparam int FL_EXTERR_BIT = 4;
    // shadow register field positions
    localparam int SH_STATUS_LSB = 8;
    localparam int SH_BANK_LSB   = 16;
    // access bank: low half of bank 0, high half of the top bank
    localparam int ACC_SPLIT_BIT = 7;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;

    // reset values
    localparam logic [20:0] PC_RST     = 21'h000000;
    localparam logic [4:0]  STATUS_RST = 5'h00;
    localparam logic [7:0]  WREG_RST   = 8'h00;
    localparam logic [3:0]  BANK_RST   = 4'h0;
    localparam logic        TMO_RST    = 1'b1;
    localparam logic        PWRDN_RST  = 1'b1;

    // opcodes
    localparam logic [7:0]  OPC_BR_OVF  = 8'he4;
    localparam logic [7:0]  OPC_BR_ZERO = 8'he0;
    localparam logic [6:0]  OPC_CALL   = 7'h76;
    localparam logic [3:0]  OPC_CALL2  = 4'hf;
    localparam logic [6:0]  OPC_CLR_REG = 7'h35;
    localparam logic [15:0] OPC_WDTCLR = 16'h0004;

    // timing: pclk cycles per quarter phase, index of the last quarter in an instruction cycle
    localparam int QTR_CYCLES  = 1;
    localparam logic [1:0] QTR_LAST = 2'h3;
    localparam logic [20:0] PC_STEP1 = 21'h000002;
    localparam logic [20:0] PC_STEP2 = 21'h000004;

    typedef enum logic [1:0] {
        BCCE_IDLE,
        BCCE_WAIT2,
        BCCE_EXEC,
        BCCE_NOP
    } bcce_state_e;
endpackage

// [bcce_core.sv]
// instruction execution unit for branches, call, register clear and watchdog clear
//
// Summary of operation
// - overflow branch opcode e4,nn jumps only when status overflow bit is set
// - zero branch opcode e0,nn jumps only when status zero bit is set
// - taken branch target is incremented pc plus twice sign-extended offset
// - branch takes one cycle, two when taken with a nop; flags untouched
// - call is two words; second word prefix f carries target bits 19..8
// - call pushes its own address plus four onto the return stack top
// - fast-save bit set copies work, status and bank into shadows
// - call target loads pc bits 20..1, bit 0 stays zero
// - call first cycle reads low byte, pushes, writes pc; second cycle nop
// - clear-register writes zero to data memory and sets zero flag
// - access bit zero selects access bank, one selects bank select register
// - watchdog clear pulses counter reset and sets timeout and powerdown flags
`timescale 1ns/1ps
module bcce_core
    import bcce_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             dm_we,
    output logic      [11:0] dm_addr,
    output logic      [7:0]  dm_wdata,
    output logic             wdt_clr,
    output logic      [1:0]  q_phase,
    output logic             exec_busy
);

    bcce_state_e st_q, st_d;
    logic [1:0]  qph_q, qph_d;
    logic [15:0] ir_q, ir_d;
    logic [15:0] ir2_q, ir2_d;
    logic [7:0]  opnd_q, opnd_d;
    logic [20:0] pc_q, pc_d;
    logic [20:0] ret_top_q, ret_top_d;
    logic [4:0]  status_q, status_d;
    logic [7:0]  wreg_q, wreg_d;
    logic [3:0]  bank_q, bank_d;
    logic [7:0]  wreg_s_q, wreg_s_d;
    logic [4:0]  status_s_q, status_s_d;
    logic [3:0]  bank_s_q, bank_s_d;
    logic        tmo_q, tmo_d;
    logic        pwrdn_q, pwrdn_d;
    logic        taken_q, taken_d;
    logic        exterr_q, exterr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        dm_we_q, dm_we_d;
    logic [11:0] dm_addr_q, dm_addr_d;
    logic        wdt_clr_q, wdt_clr_d;
    logic [7:0]  dm_wdata_q, dm_wdata_d;
    logic        busy_q, busy_d;

    logic        is_br_ovf;
    logic        is_br_zero;
    logic        is_call;
    logic        is_clr_reg;
    logic        is_wdtclr;
    logic        access;
    logic        bus_ok;
    logic [20:0] br_ofs;
    logic [3:0]  clr_bank;

    // decode happens on the held word, so it is ready in the first quarter
    assign is_br_ovf  = (ir_q[15:8] == OPC_BR_OVF);
    assign is_br_zero = (ir_q[15:8] == OPC_BR_ZERO);
    assign is_call    = (ir_q[15:9] == OPC_CALL);
    assign is_clr_reg = (ir_q[15:9] == OPC_CLR_REG);
    assign is_wdtclr = (ir_q == OPC_WDTCLR);
    assign br_ofs    = {{12{opnd_q[7]}}, opnd_q, 1'b0};
    assign clr_bank  = ir_q[8] ? bank_q
                     : (ir_q[ACC_SPLIT_BIT] ? ACC_HI_BANK : ACC_LO_BANK);
    // pready is registered: the blocking term keeps one request from being taken twice
    assign access    = psel && penable && !pready_q;
    // accesses wait out a running instruction, so software never races it
    assign bus_ok    = (st_q == BCCE_IDLE) || (st_q == BCCE_WAIT2);

    always_comb
    begin
        st_d       = st_q;
        qph_d      = qph_q;
        ir_d       = ir_q;
        ir2_d      = ir2_q;
        opnd_d     = opnd_q;
        pc_d       = pc_q;
        ret_top_d  = ret_top_q;
        status_d   = status_q;
        wreg_d     = wreg_q;
        bank_d     = bank_q;
        wreg_s_d   = wreg_s_q;
        status_s_d = status_s_q;
        bank_s_d   = bank_s_q;
        tmo_d      = tmo_q;
        pwrdn_d    = pwrdn_q;
        taken_d    = taken_q;
        exterr_d   = exterr_q;
        prdata_d   = prdata_q;
        pready_d   = 1'b0;
        pslverr_d  = 1'b0;
        dm_we_d    = 1'b0;
        dm_addr_d  = dm_addr_q;
        wdt_clr_d  = 1'b0;
        dm_wdata_d = 8'h00;
        case (st_q)
            BCCE_EXEC:
            begin
                qph_d = qph_q + 2'h1;
                case (qph_q)
                    2'h0:
                    begin
                        // step first, so the branch target and the pushed return address build on the incremented pc
                        taken_d = 1'b0;
                        pc_d    = pc_q + (is_call ? PC_STEP2 : PC_STEP1);
                    end
                    2'h1:
                    begin
                        opnd_d = ir_q[7:0];
                    end
                    2'h2:
                    begin
                        taken_d = (is_br_ovf && status_q[ST_OV_BIT])
                               || (is_br_zero && status_q[ST_Z_BIT]);
                        if (is_call)
                        begin
                            // pc already holds the call address plus four here
                            ret_top_d = pc_q;
                            if (ir_q[8])
                            begin
                                wreg_s_d   = wreg_q;
                                status_s_d = status_q;
                                bank_s_d   = bank_q;
                            end
                        end
                    end
                    default:
                    begin
                        // last quarter: every result lands on the same edge
                        if (taken_q)
                            pc_d = pc_q + br_ofs;
                        if (is_call)
                            pc_d = {ir2_q[11:0], opnd_q, 1'b0};
                        if (is_clr_reg)
                        begin
                            dm_we_d            = 1'b1;
                            dm_addr_d          = {clr_bank, ir_q[7:0]};
                            status_d[ST_Z_BIT] = 1'b1;
                        end
                        if (is_wdtclr)
                        begin
                            wdt_clr_d = 1'b1;
                            tmo_d     = 1'b1;
                            pwrdn_d   = 1'b1;
                        end
                        // flags stay as they were for branches and call
                        st_d = (taken_q || is_call) ? BCCE_NOP : BCCE_IDLE;
                    end
                endcase
            end
            BCCE_NOP:
            begin
                // dead cycle of a taken branch or call: only the quarters move
                qph_d = qph_q + 2'h1;
                if (qph_q == QTR_LAST)
                    st_d = BCCE_IDLE;
            end
            default:
            begin
                if (access && bus_ok)
                begin
                    pready_d = 1'b1;
                    prdata_d = 32'h00000000;
                    case (paddr)
                        OFS_INSTR:
                        begin
                            prdata_d = {16'h0000, ir_q};
                            if (pwrite && st_q == BCCE_WAIT2)
                            begin
                                // a bad second word abandons the call
                                if (pwdata[15:12] == OPC_CALL2)
                                begin
                                    ir2_d = pwdata[15:0];
                                    qph_d = 2'h0;
                                    st_d  = BCCE_EXEC;
                                end
                                else
                                begin
                                    exterr_d = 1'b1;
                                    st_d     = BCCE_IDLE;
                                end
                            end
                            else if (pwrite)
                            begin
                                ir_d  = pwdata[15:0];
                                qph_d = 2'h0;
                                st_d  = (pwdata[15:9] == OPC_CALL) ? BCCE_WAIT2
                                                                   : BCCE_EXEC;
                            end
                        end
                        OFS_PC:
                        begin
                            prdata_d = {11'h000, pc_q};
                            // bit 0 forced low to keep word alignment
                            if (pwrite)
                                pc_d = {pwdata[20:1], 1'b0};
                        end
                        OFS_STATUS:
                        begin
                            prdata_d = {27'h0000000, status_q};
                            if (pwrite)
                                status_d = pwdata[4:0];
                        end
                        OFS_WREG:
                        begin
                            prdata_d = {24'h000000, wreg_q};
                            if (pwrite)
                                wreg_d = pwdata[7:0];
                        end
                        OFS_BANK:
                        begin
                            prdata_d = {28'h0000000, bank_q};
                            if (pwrite)
                                bank_d = pwdata[3:0];
                        end
                        // shadows are read only; a write is answered and dropped
                        OFS_SHADOW:
                        begin
                            prdata_d[7:0]                          = wreg_s_q;
                            prdata_d[SH_STATUS_LSB +: 5]           = status_s_q;
                            prdata_d[SH_BANK_LSB +: 4]             = bank_s_q;
                        end
                        OFS_RET_TOP:
                        begin
                            prdata_d = {11'h000, ret_top_q};
                        end
                        OFS_FLAGS:
                        begin
                            prdata_d[FL_BUSY_BIT]   = busy_q;
                            prdata_d[FL_TMO_BIT]    = tmo_q;
                            prdata_d[FL_PWRDN_BIT]  = pwrdn_q;
                            prdata_d[FL_WAIT2_BIT]  = (st_q == BCCE_WAIT2);
                            prdata_d[FL_EXTERR_BIT] = exterr_q;
                            if (pwrite)
                            begin
                                // timeout/powerdown stand in for the outside sources
                                tmo_d   = pwdata[FL_TMO_BIT];
                                pwrdn_d = pwdata[FL_PWRDN_BIT];
                                if (pwdata[FL_EXTERR_BIT])
                                    exterr_d = 1'b0;
                            end
                        end
                        default:
                        begin
                            pslverr_d = 1'b1;
                        end
                    endcase
                end
            end
        endcase
        // from the next state, so busy rises on the edge that takes the word
        busy_d = (st_d == BCCE_EXEC) || (st_d == BCCE_NOP);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q       <= BCCE_IDLE;
            qph_q      <= 2'h0;
            ir_q       <= 16'h0000;
            ir2_q      <= 16'h0000;
            opnd_q     <= 8'h00;
            pc_q       <= PC_RST;
            ret_top_q  <= PC_RST;
            status_q   <= STATUS_RST;
            wreg_q     <= WREG_RST;
            bank_q     <= BANK_RST;
            wreg_s_q   <= WREG_RST;
            status_s_q <= STATUS_RST;
            bank_s_q   <= BANK_RST;
            tmo_q      <= TMO_RST;
            pwrdn_q    <= PWRDN_RST;
            taken_q    <= 1'b0;
            exterr_q   <= 1'b0;
            prdata_q   <= 32'h00000000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            dm_we_q    <= 1'b0;
            dm_addr_q  <= 12'h000;
            wdt_clr_q  <= 1'b0;
            dm_wdata_q <= 8'h00;
            busy_q     <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            qph_q      <= qph_d;
            ir_q       <= ir_d;
            ir2_q      <= ir2_d;
            opnd_q     <= opnd_d;
            pc_q       <= pc_d;
            ret_top_q  <= ret_top_d;
            status_q   <= status_d;
            wreg_q     <= wreg_d;
            bank_q     <= bank_d;
            wreg_s_q   <= wreg_s_d;
            status_s_q <= status_s_d;
            bank_s_q   <= bank_s_d;
            tmo_q      <= tmo_d;
            pwrdn_q    <= pwrdn_d;
            taken_q    <= taken_d;
            exterr_q   <= exterr_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            dm_we_q    <= dm_we_d;
            dm_addr_q  <= dm_addr_d;
            wdt_clr_q  <= wdt_clr_d;
            dm_wdata_q <= dm_wdata_d;
            busy_q     <= busy_d;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign dm_we     = dm_we_q;
    assign dm_addr   = dm_addr_q;
    // clearing only ever writes zero; still a flop like every other output
    assign dm_wdata  = dm_wdata_q;
    assign wdt_clr   = wdt_clr_q;
    assign q_phase   = qph_q;
    assign exec_busy = busy_q;

endmodule

// [bcce_monitor.sv]
// port checker for the execution unit
`timescale 1ns/1ps
module bcce_monitor
    import bcce_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dm_we,
    input wire logic [11:0] dm_addr,
    input wire logic [7:0]  dm_wdata,
    input wire logic        wdt_clr,
    input wire logic [1:0]  q_phase,
    input wire logic        exec_busy
);
    logic        issue;
    logic        clr_op;
    logic [11:0] acc_addr;
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // issue is the pready cycle, which starts on the edge that takes an instruction word
    assign issue    = pready && !pslverr && pwrite && paddr == OFS_INSTR;
    assign clr_op   = issue && pwdata[15:9] == OPC_CLR_REG;
    assign acc_addr = {pwdata[ACC_SPLIT_BIT] ? ACC_HI_BANK : ACC_LO_BANK, pwdata[7:0]};

    a_clear_writes: assert property (clr_op |-> ##4 dm_we)
        else $error("clear did not write memory");
    a_clear_zero: assert property (dm_we |-> dm_wdata == 8'h00)
        else $error("clear wrote nonzero data");
    a_clear_once: assert property
        (clr_op |-> ##1 exec_busy [*3] ##1 !exec_busy)
        else $error("clear not one cycle");
    a_access_bank: assert property
        (clr_op && !pwdata[8] |-> ##4 dm_addr == $past(acc_addr, 4))
        else $error("access bank address wrong");
    a_bank_reg: assert property
        (clr_op && pwdata[8] |-> ##4 dm_addr[7:0] == $past(pwdata[7:0], 4))
        else $error("banked register address wrong");
    a_write_q4: assert property
        (dm_we |-> $past(q_phase) == QTR_LAST && !$past(dm_we))
        else $error("memory write outside last quarter");
    a_wdt_pulse: assert property
        (issue && pwdata[15:0] == OPC_WDTCLR |-> ##4 wdt_clr ##1 !wdt_clr)
        else $error("watchdog clear pulse wrong");
    a_wdt_q4: assert property (wdt_clr |-> $past(q_phase) == QTR_LAST)
        else $error("watchdog clear off quarter");
    a_quarter_walk: assert property
        (q_phase == 2'h1 |=> q_phase == 2'h2 ##1 q_phase == QTR_LAST)
        else $error("quarter sequence broken");
    cover property (dm_we && dm_addr[11:8] == ACC_HI_BANK);
    cover property (wdt_clr);
    cover property (pslverr);
endmodule

bind bcce_core bcce_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .wdt_clr(wdt_clr),
    .q_phase(q_phase), .exec_busy(exec_busy)
);

// [bcce_dmem_model.sv]
// data memory and watchdog counter beside the execution unit
`timescale 1ns/1ps
module bcce_dmem_model
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        dm_we,
    input wire logic [11:0] dm_addr,
    input wire logic [7:0]  dm_wdata,
    input wire logic        wdt_clr
);
    logic [7:0]  mem [4096];
    logic [15:0] wdt_cnt;
    // pattern fill so a missed clear shows
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'ha5;
    end
    always @(posedge pclk)
    begin
        if (dm_we)
            mem[dm_addr] <= dm_wdata;
    end
    // starts high so a clear is visible
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_cnt <= 16'h8000;
        else if (wdt_clr)
            wdt_cnt <= 16'h0000;
        else
            wdt_cnt <= wdt_cnt + 16'h0001;
    end
endmodule

// [bcce_core_tb.sv]
// self-checking bench for the execution unit
`timescale 1ns/1ps
module bcce_core_tb
    import bcce_pkg::*;
;
    localparam logic [4:0]  BR_ST [4] = '{5'h08, 5'h04, 5'h04, 5'h08};
    localparam logic [15:0] BR_OP [4] = '{16'he010, 16'he07f, 16'he47f, 16'he480};
    localparam logic [31:0] BR_PC [4] = '{32'h1002, 32'h1100, 32'h1002, 32'h0f02};
    localparam int          BR_CY [4] = '{4, 8, 4, 8};
    localparam logic [15:0] CL_OP [3] = '{16'h6a80, 16'h6b12, 16'h6a12};
    localparam logic [11:0] CL_AD [3] = '{12'hf80, 12'h512, 12'h012};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        dm_we, wdt_clr, exec_busy;
    logic [7:0]  paddr, dm_wdata;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] dm_addr;
    logic [1:0]  q_phase;
    int          num_errors, compares, busy_cnt, busy_base;

    bcce_core DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .wdt_clr(wdt_clr),
        .q_phase(q_phase), .exec_busy(exec_busy)
    );
    bcce_dmem_model u_dmem (
        .pclk(pclk), .presetn(presetn), .dm_we(dm_we), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .wdt_clr(wdt_clr)
    );

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (exec_busy)
            busy_cnt <= busy_cnt + 1;
    end

    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge first so strobes never change twice in a step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 100)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
        {num_errors, compares, busy_cnt} = 96'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(OFS_FLAGS, 32'h6);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_STATUS, {27'h0, BR_ST[i]});
            wr(OFS_PC, 32'h1000);
            busy_base = busy_cnt;
            wr(OFS_INSTR, {16'h0, BR_OP[i]});
            rc(OFS_PC, BR_PC[i]);
            chk(busy_cnt - busy_base, BR_CY[i]);
            rc(OFS_STATUS, {27'h0, BR_ST[i]});
        end
        wr(OFS_WREG, 32'h5a);
        wr(OFS_STATUS, 32'h13);
        wr(OFS_BANK, 32'h9);
        wr(OFS_PC, 32'h2000);
        busy_base = busy_cnt;
        wr(OFS_INSTR, 32'hed34);
        wr(OFS_INSTR, 32'hfabc);
        rc(OFS_PC, 32'h157868);
        chk(busy_cnt - busy_base, 8);
        rc(OFS_RET_TOP, 32'h2004);
        rc(OFS_SHADOW, 32'h0009135a);
        wr(OFS_WREG, 32'h11);
        wr(OFS_INSTR, 32'hec00);
        wr(OFS_INSTR, 32'hf001);
        rc(OFS_SHADOW, 32'h0009135a);
        rc(OFS_RET_TOP, 32'h15786c);
        rc(OFS_PC, 32'h200);
        // bad second word abandons the call
        wr(OFS_INSTR, 32'hec00);
        rc(OFS_FLAGS, 32'he);
        wr(OFS_INSTR, 32'h1234);
        rc(OFS_PC, 32'h200);
        rc(OFS_FLAGS, 32'h16);
        wr(OFS_FLAGS, 32'h16);
        rc(OFS_FLAGS, 32'h6);
        wr(OFS_BANK, 32'h5);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_STATUS, 32'h0);
            wr(OFS_INSTR, {16'h0, CL_OP[i]});
            rc(OFS_STATUS, 32'h4);
            chk({24'h0, u_dmem.mem[CL_AD[i]]}, 32'h0);
        end
        wr(OFS_FLAGS, 32'h0);
        rc(OFS_FLAGS, 32'h0);
        wr(OFS_INSTR, 32'h0004);
        rc(OFS_FLAGS, 32'h6);
        chk({31'h0, u_dmem.wdt_cnt < 16'h0010}, 32'h1);
        // plain nop: clears and watchdog clear each stepped pc by one word
        wr(OFS_INSTR, 32'h0000);
        rc(OFS_PC, 32'h20a);
        wr(OFS_SHADOW, 32'hffffffff);
        rc(OFS_SHADOW, 32'h0009135a);
        xfer(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule
